// *** src/watchdog_halt_wakeup.sv ***
// Watchdog with halt entry, wake-up sources and reset-cause flags.
// Assumes the core pulses halt/clear strobes and holds state while halted.
// How it works
// (R1) Halt high-keep only: high clock on, low stops
// (R2) Halt holds memory, registers, port state
// (R3) Halt sets power-down, clears time-out flag
// (R4) Halt clears watchdog counter, counting resumes
// (R5) Wake on port fall, interrupt, overflow
// (R6) Power-down flag cleared by power-up, clear-instruction
// (R7) Halted overflow: time-out set, PC/SP reset only
// (R8) Per-pin wake enable; resume after halt
// (R9) Disabled or stack-full interrupt: resume, stays pending
// (R10) Enabled interrupt with room: normal response
// (R11) Flag already set before halt: no wake
// (R12) Watchdog counts low-speed RC, power-two divide
// (R13) Select codes map 2^8..2^18 periods
// (R14) Valid keys enable; others reset after delay
// (R15) Bad-key reset sets flag; software clears
// (R16) Key resets to enable value, select 011
// (R17) Running time-out: full reset, time-out flag set
// (R18) Counter cleared by bad key, clear, halt
// (R19) Software clears watchdog before time-out
// (R20) Halt both keeps zero: only watchdog runs
// (R21) Overflow at selected count; restart afterwards
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ns
module watchdog_halt_wakeup (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic halt_i,
  input wire logic clear_watchdog_i,
  input wire logic [7:0] porta_i,
  input wire logic irq_req_i,
  input wire logic irq_enabled_i,
  input wire logic stack_full_i,
  output logic halted_o,
  output logic high_clock_run_o,
  output logic low_clock_run_o,
  output logic device_reset_o,
  output logic pc_sp_reset_o,
  output logic irq_take_o,
  output logic power_down_flag_o,
  output logic timeout_flag_o
);
  wdt_pkg::pwr_state_t st_r, st_nxt;
  logic [7:0] watchdog_control_r, watchdog_control_nxt;
  logic [1:0] clock_mode_r, clock_mode_nxt;
  logic [7:0] wake_en_r, wake_en_nxt;
  logic srf_r, srf_nxt;
  logic pdf_r, pdf_nxt;
  logic to_r, to_nxt;
  logic [18:0] cnt_r, cnt_nxt;
  logic [15:0] sdly_r, sdly_nxt;
  logic [2:0] rpulse_r, rpulse_nxt;
  logic [7:0] pa_prev_r;
  logic irq_block_r, irq_block_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wait_r, wait_nxt;
  logic halted_nxt, hclk_nxt, lclk_nxt, dev_rst_nxt, pcsp_nxt, irq_take_nxt;
  logic tick;
  logic tick_run;
  logic key_ok;
  logic overflow;
  logic [18:0] limit;
  logic acc;
  logic wr_hit;
  logic [7:0] wd;
  logic pin_wake;

  // Watchdog clock always runs: it survives every low-power mode [R20]
  assign tick_run = 1'b1;

  low_speed_rc_tick #(.DIV(wdt_pkg::LOW_SPEED_RC_DIV)) u_tick (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .run_i(tick_run),
    .tick_o(tick)
  );

  assign key_ok = (watchdog_control_r[7:wdt_pkg::KEY_LSB] == wdt_pkg::KEY_A) ||
                  (watchdog_control_r[7:wdt_pkg::KEY_LSB] == wdt_pkg::KEY_B); // [R14]

  // Period table in low-speed cycles [R13]
  always_comb begin
    unique case (watchdog_control_r[2:0])
      3'h0: limit = 19'h0_0100;
      3'h1: limit = 19'h0_0400;
      3'h2: limit = 19'h0_1000;
      3'h3: limit = 19'h0_4000;
      3'h4: limit = 19'h0_8000;
      3'h5: limit = 19'h1_0000;
      3'h6: limit = 19'h2_0000;
      3'h7: limit = 19'h4_0000;
    endcase
  end

  assign overflow = tick && key_ok && (cnt_r == limit - 19'h0_0001); // [R12] [R21]
  assign pin_wake = |(pa_prev_r & ~porta_i & wake_en_r); // [R8]
  assign acc = (avs_read || avs_write) && wait_r;
  // Write commits only at the edge where waitrequest is seen low
  assign wr_hit = avs_write && !wait_r;
  assign wd = avs_writedata[7:0];

  always_comb begin
    st_nxt = st_r;
    watchdog_control_nxt = watchdog_control_r;
    clock_mode_nxt = clock_mode_r;
    wake_en_nxt = wake_en_r;
    srf_nxt = srf_r;
    pdf_nxt = pdf_r;
    to_nxt = to_r;
    cnt_nxt = cnt_r;
    sdly_nxt = sdly_r;
    rpulse_nxt = (rpulse_r != 3'h0) ? rpulse_r - 3'h1 : 3'h0;
    irq_block_nxt = irq_block_r;
    rdata_nxt = rdata_r;
    wait_nxt = 1'b1;
    pcsp_nxt = 1'b0;
    irq_take_nxt = 1'b0;
    // Register slave: one wait cycle, then answer
    if (acc) begin
      wait_nxt = 1'b0;
      rdata_nxt = 32'h0000_0000;
      unique case (avs_address)
        wdt_pkg::OFS_WDT_CONTROL: rdata_nxt[7:0] = watchdog_control_r;
        wdt_pkg::OFS_RESET_FLAGS: rdata_nxt[wdt_pkg::SRF_BIT] = srf_r;
        wdt_pkg::OFS_CLOCK_MODE: rdata_nxt[1:0] = clock_mode_r;
        wdt_pkg::OFS_WAKE_ENABLE: rdata_nxt[7:0] = wake_en_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_hit) begin
      begin
        unique case (avs_address)
          wdt_pkg::OFS_WDT_CONTROL: watchdog_control_nxt = wd;
          wdt_pkg::OFS_RESET_FLAGS: begin
            // Only a written zero clears [R15]
            if (!wd[wdt_pkg::SRF_BIT]) begin
              srf_nxt = 1'b0;
            end
          end
          wdt_pkg::OFS_CLOCK_MODE: clock_mode_nxt = wd[1:0];
          wdt_pkg::OFS_WAKE_ENABLE: wake_en_nxt = wd;
          default: ;
        endcase
      end
    end
    if (tick && key_ok) begin
      cnt_nxt = overflow ? 19'h0_0000 : cnt_r + 19'h0_0001; // [R21]
    end
    unique case (st_r)
      wdt_pkg::ST_RUN: begin
        if (!key_ok) begin
          // Bad key: counter held clear, reset after delay [R14] [R18]
          cnt_nxt = 19'h0_0000;
          st_nxt = wdt_pkg::ST_SRESET;
          sdly_nxt = 16'(wdt_pkg::SRESET_CYC - 1);
        end else if (overflow) begin
          to_nxt = 1'b1; // [R17]
          rpulse_nxt = 3'(wdt_pkg::RST_PULSE_CYC);
        end else if (halt_i) begin
          st_nxt = wdt_pkg::ST_HALT;
          pdf_nxt = 1'b1; // [R3]
          to_nxt = 1'b0; // [R3]
          cnt_nxt = 19'h0_0000; // [R4] [R18]
          irq_block_nxt = irq_req_i; // [R11]
        end else if (clear_watchdog_i) begin
          cnt_nxt = 19'h0_0000; // [R18]
          pdf_nxt = 1'b0; // [R6]
        end
      end
      wdt_pkg::ST_HALT: begin
        // Registers and ports frozen: only the flags below and the watchdog counter change [R2]
        if (overflow) begin
          to_nxt = 1'b1; // [R7]
          pcsp_nxt = 1'b1; // [R7]
          st_nxt = wdt_pkg::ST_RUN; // [R5]
        end else if (pin_wake) begin
          st_nxt = wdt_pkg::ST_RUN; // [R5] [R8]
        end else if (irq_req_i && !irq_block_r) begin
          st_nxt = wdt_pkg::ST_RUN; // [R5]
          // Enabled with stack room takes the vector, else stays pending
          irq_take_nxt = irq_enabled_i && !stack_full_i; // [R9] [R10]
        end
      end
      wdt_pkg::ST_SRESET: begin
        cnt_nxt = 19'h0_0000; // [R18]
        if (sdly_r == 16'h0000) begin
          st_nxt = wdt_pkg::ST_RUN;
          srf_nxt = 1'b1; // [R15]
          watchdog_control_nxt = wdt_pkg::WDT_CONTROL_RST;
          rpulse_nxt = 3'(wdt_pkg::RST_PULSE_CYC);
        end else begin
          sdly_nxt = sdly_r - 16'h0001;
        end
      end
      default: st_nxt = wdt_pkg::ST_RUN;
    endcase
    halted_nxt = (st_nxt == wdt_pkg::ST_HALT); // [R1]
    // High clock kept only by its keep bit while halted [R1] [R20]
    hclk_nxt = !halted_nxt || clock_mode_nxt[wdt_pkg::HCK_BIT];
    lclk_nxt = !halted_nxt || clock_mode_nxt[wdt_pkg::LCK_BIT];
    dev_rst_nxt = (rpulse_nxt != 3'h0);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= wdt_pkg::ST_RUN;
      watchdog_control_r <= wdt_pkg::WDT_CONTROL_RST; // [R16]
      clock_mode_r <= 2'h0;
      wake_en_r <= 8'h00;
      srf_r <= 1'b0;
      pdf_r <= 1'b0; // [R6]
      to_r <= 1'b0;
      cnt_r <= 19'h0_0000;
      sdly_r <= 16'h0000;
      rpulse_r <= 3'h0;
      pa_prev_r <= 8'hFF;
      irq_block_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      wait_r <= 1'b1;
      halted_o <= 1'b0;
      high_clock_run_o <= 1'b1;
      low_clock_run_o <= 1'b1;
      device_reset_o <= 1'b0;
      pc_sp_reset_o <= 1'b0;
      irq_take_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      watchdog_control_r <= watchdog_control_nxt;
      clock_mode_r <= clock_mode_nxt;
      wake_en_r <= wake_en_nxt;
      srf_r <= srf_nxt;
      pdf_r <= pdf_nxt;
      to_r <= to_nxt;
      cnt_r <= cnt_nxt;
      sdly_r <= sdly_nxt;
      rpulse_r <= rpulse_nxt;
      pa_prev_r <= porta_i;
      irq_block_r <= irq_block_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      halted_o <= halted_nxt;
      high_clock_run_o <= hclk_nxt;
      low_clock_run_o <= lclk_nxt;
      device_reset_o <= dev_rst_nxt;
      pc_sp_reset_o <= pcsp_nxt;
      irq_take_o <= irq_take_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign power_down_flag_o = pdf_r;
  assign timeout_flag_o = to_r;
endmodule

// *** inc/wdt_pkg.sv ***
// Package: offsets, reset values, fields and timing for the watchdog/halt block.
// Assumes a 100 MHz system clock and an Avalon-MM register slave.
package wdt_pkg;
  localparam logic [3:0] OFS_WDT_CONTROL = 4'h0;
  localparam logic [3:0] OFS_RESET_FLAGS = 4'h4;
  localparam logic [3:0] OFS_CLOCK_MODE = 4'h8;
  localparam logic [3:0] OFS_WAKE_ENABLE = 4'hC;
  localparam logic [7:0] WDT_CONTROL_RST = 8'h53;
  localparam logic [4:0] KEY_A = 5'h0A;
  localparam logic [4:0] KEY_B = 5'h15;
  localparam int KEY_LSB = 3;
  localparam int SRF_BIT = 0;
  localparam int LOW_VOLTAGE_RESET_FLAG_BIT = 2;
  localparam int HCK_BIT = 1;
  localparam int LCK_BIT = 0;
  localparam int PA_W = 8;
  localparam int CNT_W = 19;
  localparam int CLK_HZ = 100_000_000;
  localparam int LOW_SPEED_RC_HZ = 32_000;
  // Low-speed tick divider; rounded down to whole system cycles
  localparam int LOW_SPEED_RC_DIV = CLK_HZ / LOW_SPEED_RC_HZ;
  localparam int SRESET_US = 64;
  localparam int SRESET_CYC = (SRESET_US * (CLK_HZ / 1_000_000));
  localparam int RST_PULSE_CYC = 4;
  typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_SRESET} pwr_state_t;
endpackage

// *** src/low_speed_rc_tick.sv ***
// Divider making a one-cycle low-speed RC tick enable from the system clock.
// Assumes one system clock; the tick can be gated off for clock-stop modes.
`timescale 1ns/1ns
module low_speed_rc_tick #(
  parameter int DIV = 3125
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic run_i,
  output logic tick_o
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic tick_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (run_i) begin
      if (cnt_r == 16'(DIV - 1)) begin
        cnt_nxt = 16'h0000;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end
endmodule

// *** testbench/wdt_assertions.sv ***
// Checker: port properties of the watchdog halt block.
// Assumes a bind onto watchdog_halt_wakeup; one clock domain.
`timescale 1ns/1ns
module wdt_assertions (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic halt_i,
  input wire logic clear_watchdog_i,
  input wire logic irq_req_i,
  input wire logic [7:0] porta_i,
  input wire logic halted_o,
  input wire logic device_reset_o,
  input wire logic power_down_flag_o,
  input wire logic timeout_flag_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence s_halt;
    halt_i && !halted_o;
  endsequence
  sequence s_irq_rise;
    halted_o && $rose(irq_req_i);
  endsequence
  a_halt_flags: assert property (s_halt |=> halted_o && power_down_flag_o && !timeout_flag_o)
    else $error("halt entry flags wrong");
  a_pdf_clear: assert property (clear_watchdog_i && !halted_o && !halt_i |=> !power_down_flag_o)
    else $error("clear left power-down set");
  a_pdf_cause: assert property ($fell(power_down_flag_o) |-> $past(clear_watchdog_i))
    else $error("power-down cleared without clear");
  a_pdf_halted: assert property (halted_o |-> power_down_flag_o)
    else $error("halted without power-down flag");
  a_to_clear: assert property ($fell(timeout_flag_o) |-> $past(halt_i))
    else $error("time-out cleared without halt");
  a_irq_wake: assert property (s_irq_rise |=> !halted_o)
    else $error("interrupt did not wake");
  // Stale request plus quiet port must keep the core stopped
  a_irq_stale: assert property ((s_halt and irq_req_i) ##1 (irq_req_i && $stable(porta_i)) [*4]
    |-> halted_o)
    else $error("stale interrupt woke core");
  a_rst_pulse: assert property ($rose(device_reset_o) |-> device_reset_o [*4] ##1 !device_reset_o)
    else $error("device reset pulse length");
endmodule

// *** testbench/core_model.sv ***
// Partner: core issuing halt and clear-watchdog strobes.
// Assumes one-cycle requests from the bench.
`timescale 1ns/1ns
module core_model (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic halted_i,
  input wire logic do_halt_i,
  input wire logic do_clear_i,
  output logic halt_o,
  output logic clear_o
);
  logic halt_nxt;
  logic clear_nxt;
  // A stopped core executes nothing
  always_comb begin
    halt_nxt = do_halt_i && !halted_i;
    clear_nxt = do_clear_i && !halted_i;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      halt_o <= 1'b0;
      clear_o <= 1'b0;
    end else begin
      halt_o <= halt_nxt;
      clear_o <= clear_nxt;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// Testbench: registers over Avalon-MM, halt, wake and bad key.
// Assumes design, checker and core model compiled first.
`timescale 1ns/1ns
module tb_top;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rdata;
  logic avs_waitrequest, halt_i, clear_watchdog_i, halted_o, high_clk, low_clk, dev_rst;
  logic pc_sp, irq_take_o, power_down_flag, to, do_halt = 1'b0, do_clear = 1'b0, took;
  logic [7:0] porta_i = 8'hFF, m;
  logic irq_req_i = 1'b0, irq_en = 1'b0, stack_full = 1'b0;
  int num_errors = 0, n_checks = 0, cycles = 0, cnt;
  int regs [4] = '{32'h0000_0053, 0, 0, 0};
  integer seed = 62;
  always #5 clk_sys_i = ~clk_sys_i;
  watchdog_halt_wakeup watchdog_halt_wakeup_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .halt_i(halt_i), .clear_watchdog_i(clear_watchdog_i),
    .porta_i(porta_i), .irq_req_i(irq_req_i), .irq_enabled_i(irq_en), .stack_full_i(stack_full),
    .halted_o(halted_o), .high_clock_run_o(high_clk), .low_clock_run_o(low_clk),
    .device_reset_o(dev_rst), .pc_sp_reset_o(pc_sp), .irq_take_o(irq_take_o),
    .power_down_flag_o(power_down_flag), .timeout_flag_o(to));
  core_model core_model_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .halted_i(halted_o),
    .do_halt_i(do_halt), .do_clear_i(do_clear), .halt_o(halt_i), .clear_o(clear_watchdog_i));
  task automatic stop_test;
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h00_0000, d};
    do @(posedge clk_sys_i); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (w) regs[a[3:2]] = d;
  endtask
  task automatic rchk(input logic [3:0] a);
    bus(1'b0, a, 8'h00);
    chk("readdata", rdata, (a[1:0] == 2'b00) ? regs[a[3:2]] : 0);
  endtask
  task automatic rall;
    for (int i = 0; i < 4; i++) rchk(4'(i * 4));
  endtask
  task automatic core(input logic h);
    @(posedge clk_sys_i);
    do_halt <= h;
    do_clear <= !h;
    @(posedge clk_sys_i);
    do_halt <= 1'b0;
    do_clear <= 1'b0;
    tick(3);
  endtask
  task automatic irq_case(input logic en, input logic full);
    core(1'b1);
    irq_en <= en;
    stack_full <= full;
    irq_req_i <= 1'b1;
    took = 1'b0;
    repeat (4) begin
      @(posedge clk_sys_i);
      took = took | irq_take_o;
    end
    chk("irq_take_o", took, en & !full);
    chk("halted_o", halted_o, 1'b0);
    irq_req_i <= 1'b0;
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test;
    end
  end
  initial begin
    tick(4);
    nrst_i <= 1'b1;
    rall;
    rchk(4'h2);
    m = (8'($random(seed)) | 8'h01) & 8'h7F;
    bus(1'b1, wdt_pkg::OFS_WAKE_ENABLE, m);
    bus(1'b1, wdt_pkg::OFS_CLOCK_MODE, 8'h02);
    bus(1'b1, wdt_pkg::OFS_WDT_CONTROL, {wdt_pkg::KEY_B, 3'(m)});
    rall;
    core(1'b1);
    chk("halted_o", halted_o, 1'b1);
    chk("pdf", power_down_flag, 1'b1);
    chk("to", to, 1'b0);
    chk("high_clk", high_clk, 1'b1);
    chk("low_clk", low_clk, 1'b0);
    rall;
    porta_i <= 8'h7F;
    tick(4);
    chk("halted_o", halted_o, 1'b1);
    porta_i <= 8'h7E;
    tick(3);
    chk("halted_o", halted_o, 1'b0);
    porta_i <= 8'hFF;
    core(1'b0);
    chk("pdf", power_down_flag, 1'b0);
    irq_req_i <= 1'b1;
    core(1'b1);
    tick(4);
    chk("halted_o", halted_o, 1'b1);
    irq_req_i <= 1'b0;
    porta_i <= 8'hFE;
    tick(3);
    porta_i <= 8'hFF;
    for (int i = 0; i < 3; i++) irq_case(i > 0, i == 1);
    bus(1'b1, wdt_pkg::OFS_WDT_CONTROL, 8'h03);
    for (cnt = 0; dev_rst !== 1'b1 && cnt < 8000; cnt++) @(posedge clk_sys_i);
    chk("delay", cnt >= wdt_pkg::SRESET_CYC - 3 && cnt <= wdt_pkg::SRESET_CYC + 3, 1'b1);
    tick(10);
    regs[0] = 32'h0000_0053;
    regs[1] = 1;
    rchk(wdt_pkg::OFS_WDT_CONTROL);
    rchk(wdt_pkg::OFS_RESET_FLAGS);
    bus(1'b1, wdt_pkg::OFS_RESET_FLAGS, 8'h00);
    rchk(wdt_pkg::OFS_RESET_FLAGS);
    stop_test;
  end
endmodule
bind watchdog_halt_wakeup wdt_assertions wdt_assertions_inst (.clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i), .halt_i(halt_i), .clear_watchdog_i(clear_watchdog_i), .porta_i(porta_i),
  .irq_req_i(irq_req_i), .halted_o(halted_o), .device_reset_o(device_reset_o),
  .power_down_flag_o(power_down_flag_o), .timeout_flag_o(timeout_flag_o));
